// [common/usb_clkctl_defines.vh]
// Constants for the USB clock-domain sequencer: device register map, field positions,
// our own AHB register map and timing figures.
// Assumes a 250 MHz system clock and the device register port described in the top module.
`ifndef USB_CLKCTL_DEFINES_VH
`define USB_CLKCTL_DEFINES_VH

// Device register addresses on the device access port.
`define UCC_SCR_ADDR 16'h1C32
`define UCC_PMR_ADDR 16'h0001
`define UCC_CLOCK_STOP_HANDSHAKE_REG_ADDR 16'h1C3A
`define UCC_CLOCK_GATING_CTRL_2_ADDR 16'h1C03

// Fields of usb_sys_ctrl_reg.
`define UCC_SCR_PWDN 15
`define UCC_SCR_SESSEND 14
`define UCC_SCR_VBUSDET 13
`define UCC_SCR_PLLOVR 12
`define UCC_SCR_POL 6
`define UCC_SCR_BIASOFF 3
`define UCC_SCR_OSCDIS 2
`define UCC_SCR_BYTE_HI 1
`define UCC_SCR_BYTE_LO 0
`define UCC_SCR_WR_MASK 16'hF04F
`define UCC_SCR_RESET 16'hA04C
`define UCC_BYTE_RSVD 2'h3

// Other device fields.
`define UCC_CLOCK_STOP_HANDSHAKE_REG_REQ_BIT 2
`define UCC_CLOCK_STOP_HANDSHAKE_REG_ACK_BIT 3
`define UCC_PMR_SUSPEND_BIT 0
`define UCC_CLOCK_GATING_CTRL_2_GATE_BIT 0

// Our own registers, byte offsets on AHB.
`define UCC_OFS_CTRL 4'h0
`define UCC_OFS_CFG 4'h4
`define UCC_OFS_STATUS 4'h8
`define UCC_OFS_STAB 4'hC

// Fields of our registers.
`define UCC_CTRL_SHUTDOWN 0
`define UCC_CTRL_WAKEUP 1
`define UCC_CTRL_APPLY 2
`define UCC_CTRL_PROTOCOL 3
`define UCC_ST_BUSY 0
`define UCC_ST_DONE 1
`define UCC_ST_ERROR 2
`define UCC_ST_DOMAIN_OFF 3
`define UCC_ST_FS_CLK_OK 4
`define UCC_ST_HS_CLK_OK 5

// Sequencer step operations.
`define UCC_OP_SET 3'h0
`define UCC_OP_CLR 3'h1
`define UCC_OP_POLL 3'h2
`define UCC_OP_WAIT 3'h3
`define UCC_OP_LOAD 3'h4

// Timing.
`define UCC_CLK_MHZ 250
`define UCC_MIN_FS_MHZ 30
`define UCC_MIN_HS_MHZ 60
`define UCC_STAB_TIME_US 10
`define UCC_STAB_CYCLES (`UCC_STAB_TIME_US * `UCC_CLK_MHZ)
`define UCC_POLL_LIMIT 16'h0100

`endif

// [logic/dev_access.v]
// Single-access engine for the device register port.
// Assumes the device answers each request by a one-cycle DEV_ACK while the request stands.
`timescale 1ns/1ns
module dev_access #(
	parameter AW = 16,
	parameter DW = 16
) (
	input wire clk,
	input wire rst,
	input wire start,
	input wire wr,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg done_r,
	output reg [DW-1:0] rdata_r,
	output reg req_r,
	output reg we_r,
	output reg [AW-1:0] addr_r,
	output reg [DW-1:0] wdata_r,
	input wire [DW-1:0] dev_rdata,
	input wire dev_ack
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
			rdata_r <= {DW{1'b0}};
			req_r <= 1'b0;
			we_r <= 1'b0;
			addr_r <= {AW{1'b0}};
			wdata_r <= {DW{1'b0}};
		end else begin
			done_r <= 1'b0;
			if (req_r && dev_ack) begin
				req_r <= 1'b0;
				done_r <= 1'b1;
				if (!we_r)
					rdata_r <= dev_rdata;
			end else if (start && !req_r) begin
				req_r <= 1'b1;
				we_r <= wr;
				addr_r <= addr;
				wdata_r <= wdata;
			end
		end
	end
endmodule

// [logic/usb_clk_sequencer.v]
// Host-side sequencer that idles and wakes the USB clock domain and programs its
// system control register through the device register port.
// Assumes software on AHB-Lite as the only master and a device port that acks every access.
`timescale 1ns/1ns
`include "usb_clkctl_defines.vh"

// Contract
// - Core system clock must be at least 30 MHz, 60 MHz for high speed.
// - Host sets the PHY suspend request before any clock stop request.
// - Host requests clock stop, polls the acknowledge, never gates before it.
// - After acknowledge, host writes 1 to the peripheral clock gate bit.
// - Last shut-down step: host writes 1 to the oscillator disable bit.
// - Wake-up starts by writing 0 to the oscillator disable bit.
// - Host waits the oscillator stabilization time before ungating the clock.
// - After stabilization, host writes 0 to the peripheral clock gate bit.
// - Only after ungating may the host clear the clock stop request.
// - Last wake-up step: host clears the PHY suspend request.
// - Bits 11 to 7 are reserved, read 0, always written 0.
// - Full shut-down must not be used where suspend/resume must be honoured.
module usb_clk_sequencer #(
	parameter [31:0] STAB_CYCLES = `UCC_STAB_CYCLES,
	parameter [15:0] POLL_LIMIT = `UCC_POLL_LIMIT
) (
	input wire CLK_SYS,
	input wire RST,
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output wire HREADYOUT,
	output wire HRESP,
	output reg [31:0] HRDATA,
	output wire DEV_REQ,
	output wire DEV_WE,
	output wire [15:0] DEV_ADDR,
	output wire [15:0] DEV_WDATA,
	input wire [15:0] DEV_RDATA,
	input wire DEV_ACK
);
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_FETCH = 6'h02;
	localparam [5:0] S_READ = 6'h04;
	localparam [5:0] S_WRITE = 6'h08;
	localparam [5:0] S_STAB = 6'h10;
	localparam [5:0] S_NEXT = 6'h20;

	localparam [1:0] M_SHUT = 2'h0;
	localparam [1:0] M_WAKE = 2'h1;
	localparam [1:0] M_CFG = 2'h2;

	reg [5:0] state_r;
	reg [5:0] state_nxt;
	reg [1:0] mode_r;
	reg [2:0] step_r;
	reg [15:0] cfg_r;
	reg [31:0] stab_r;
	reg [31:0] count_r;
	reg [15:0] poll_r;
	reg protocol_r;
	reg done_r;
	reg error_r;
	reg domain_off_r;
	reg wr_pend_r;
	reg [3:0] wr_ofs_r;

	reg acc_start;
	reg acc_wr;
	reg [15:0] acc_wdata;
	wire acc_done;
	wire [15:0] acc_rdata;

	reg [2:0] st_op;
	reg [15:0] st_addr;
	reg [15:0] st_mask;
	reg st_last;

	wire fs_clk_ok = (`UCC_CLK_MHZ >= `UCC_MIN_FS_MHZ);
	wire hs_clk_ok = (`UCC_CLK_MHZ >= `UCC_MIN_HS_MHZ);

	// Writes land in the data phase, so the slave never needs a wait state.
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	wire addr_phase = HSEL && HREADY && HTRANS[1];
	wire busy = !state_r[0];

	// Step table: each sequence is a short list of set, clear, poll, wait and load steps.
	always @* begin
		st_op = `UCC_OP_SET;
		st_addr = `UCC_SCR_ADDR;
		st_mask = 16'h0000;
		st_last = 1'b0;
		case (mode_r)
			M_SHUT: begin
				case (step_r)
					3'h0: begin
						st_op = `UCC_OP_SET;
						st_addr = `UCC_PMR_ADDR;
						st_mask = 16'h0001 << `UCC_PMR_SUSPEND_BIT;
					end
					3'h1: begin
						st_op = `UCC_OP_SET;
						st_addr = `UCC_CLOCK_STOP_HANDSHAKE_REG_ADDR;
						st_mask = 16'h0001 << `UCC_CLOCK_STOP_HANDSHAKE_REG_REQ_BIT;
					end
					3'h2: begin
						st_op = `UCC_OP_POLL;
						st_addr = `UCC_CLOCK_STOP_HANDSHAKE_REG_ADDR;
						st_mask = 16'h0001 << `UCC_CLOCK_STOP_HANDSHAKE_REG_ACK_BIT;
					end
					3'h3: begin
						st_op = `UCC_OP_SET;
						st_addr = `UCC_CLOCK_GATING_CTRL_2_ADDR;
						st_mask = 16'h0001 << `UCC_CLOCK_GATING_CTRL_2_GATE_BIT;
					end
					default: begin
						st_op = `UCC_OP_SET;
						st_addr = `UCC_SCR_ADDR;
						st_mask = 16'h0001 << `UCC_SCR_OSCDIS;
						st_last = 1'b1;
					end
				endcase
			end
			M_WAKE: begin
				case (step_r)
					3'h0: begin
						st_op = `UCC_OP_CLR;
						st_addr = `UCC_SCR_ADDR;
						st_mask = 16'h0001 << `UCC_SCR_OSCDIS;
					end
					3'h1: begin
						st_op = `UCC_OP_WAIT;
					end
					3'h2: begin
						st_op = `UCC_OP_CLR;
						st_addr = `UCC_CLOCK_GATING_CTRL_2_ADDR;
						st_mask = 16'h0001 << `UCC_CLOCK_GATING_CTRL_2_GATE_BIT;
					end
					3'h3: begin
						st_op = `UCC_OP_CLR;
						st_addr = `UCC_CLOCK_STOP_HANDSHAKE_REG_ADDR;
						st_mask = 16'h0001 << `UCC_CLOCK_STOP_HANDSHAKE_REG_REQ_BIT;
					end
					default: begin
						st_op = `UCC_OP_CLR;
						st_addr = `UCC_PMR_ADDR;
						st_mask = 16'h0001 << `UCC_PMR_SUSPEND_BIT;
						st_last = 1'b1;
					end
				endcase
			end
			default: begin
				st_op = `UCC_OP_LOAD;
				st_addr = `UCC_SCR_ADDR;
				st_mask = cfg_r & `UCC_SCR_WR_MASK;
				st_last = 1'b1;
			end
		endcase
	end

	// Sequencer next state and device access requests.
	always @* begin
		state_nxt = state_r;
		acc_start = 1'b0;
		acc_wr = 1'b0;
		acc_wdata = 16'h0000;
		case (state_r)
			S_IDLE: begin
				state_nxt = S_IDLE;
			end
			S_FETCH: begin
				if (st_op == `UCC_OP_WAIT) begin
					state_nxt = S_STAB;
				end else if (st_op == `UCC_OP_LOAD) begin
					acc_start = 1'b1;
					acc_wr = 1'b1;
					acc_wdata = st_mask;
					state_nxt = S_WRITE;
				end else begin
					acc_start = 1'b1;
					state_nxt = S_READ;
				end
			end
			S_READ: begin
				if (acc_done) begin
					if (st_op == `UCC_OP_POLL) begin
						if ((acc_rdata & st_mask) != 16'h0000)
							state_nxt = S_NEXT;
						else if (poll_r == POLL_LIMIT - 16'h0001)
							state_nxt = S_IDLE;
						else
							state_nxt = S_FETCH;
					end else begin
						acc_start = 1'b1;
						acc_wr = 1'b1;
						if (st_op == `UCC_OP_SET)
							acc_wdata = acc_rdata | st_mask;
						else
							acc_wdata = acc_rdata & ~st_mask;
						// Reserved SCR bits are never written back as read.
						if (st_addr == `UCC_SCR_ADDR)
							acc_wdata = acc_wdata & `UCC_SCR_WR_MASK;
						state_nxt = S_WRITE;
					end
				end
			end
			S_WRITE: begin
				if (acc_done)
					state_nxt = S_NEXT;
			end
			S_STAB: begin
				if (count_r >= stab_r)
					state_nxt = S_NEXT;
			end
			S_NEXT: begin
				state_nxt = st_last ? S_IDLE : S_FETCH;
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	// Commands taken from a CTRL write while idle; a write while busy starts nothing but still stores the protocol bit.
	wire cmd_shut = HWDATA[`UCC_CTRL_SHUTDOWN] && !HWDATA[`UCC_CTRL_WAKEUP];
	wire cmd_wake = HWDATA[`UCC_CTRL_WAKEUP] && !HWDATA[`UCC_CTRL_SHUTDOWN];
	wire cmd_apply = HWDATA[`UCC_CTRL_APPLY] && !HWDATA[`UCC_CTRL_SHUTDOWN] && !HWDATA[`UCC_CTRL_WAKEUP];
	// Full shut-down kills the module outright, so it is refused while the protocol must be honoured,
	// whether that mode is already stored or arrives in the same write as the command.
	wire shut_refused = cmd_shut && (protocol_r || HWDATA[`UCC_CTRL_PROTOCOL]);
	wire apply_refused = cmd_apply && (cfg_r[1:0] == `UCC_BYTE_RSVD);
	wire error_r_block = shut_refused || apply_refused;
	wire cmd_refused = state_r[0] && wr_pend_r && wr_ofs_r == `UCC_OFS_CTRL && error_r_block;

	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_r <= S_IDLE;
			mode_r <= M_SHUT;
			step_r <= 3'h0;
			count_r <= 32'h00000000;
			poll_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			if (state_r[0] && wr_pend_r && wr_ofs_r == `UCC_OFS_CTRL && !error_r_block) begin
				if (cmd_shut) begin
					mode_r <= M_SHUT;
					step_r <= 3'h0;
					state_r <= S_FETCH;
				end else if (cmd_wake) begin
					mode_r <= M_WAKE;
					step_r <= 3'h0;
					state_r <= S_FETCH;
				end else if (cmd_apply) begin
					mode_r <= M_CFG;
					step_r <= 3'h0;
					state_r <= S_FETCH;
				end
			end
			if (state_r == S_NEXT)
				step_r <= step_r + 3'h1;
			if (state_r == S_STAB)
				count_r <= count_r + 32'h00000001;
			else
				count_r <= 32'h00000000;
			if (state_r == S_READ && acc_done && st_op == `UCC_OP_POLL)
				poll_r <= poll_r + 16'h0001;
			else if (state_r == S_NEXT || state_r[0])
				poll_r <= 16'h0000;
		end
	end

	wire seq_end = state_r == S_NEXT && st_last;
	wire poll_fail = state_r == S_READ && acc_done && st_op == `UCC_OP_POLL && state_nxt == S_IDLE;

	// AHB slave registers and sticky status.
	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 4'h0;
			HRDATA <= 32'h00000000;
			cfg_r <= `UCC_SCR_RESET;
			stab_r <= STAB_CYCLES;
			protocol_r <= 1'b0;
			done_r <= 1'b0;
			error_r <= 1'b0;
			domain_off_r <= 1'b0;
		end else begin
			wr_pend_r <= addr_phase && HWRITE && HADDR[31:4] == 28'h0000000;
			wr_ofs_r <= {HADDR[3:2], 2'b00};
			if (addr_phase && !HWRITE) begin
				case ({HADDR[3:2], 2'b00})
					`UCC_OFS_CTRL: HRDATA <= {28'h0000000, protocol_r, 3'b000};
					`UCC_OFS_CFG: HRDATA <= {16'h0000, cfg_r};
					`UCC_OFS_STATUS: HRDATA <= {26'h0, hs_clk_ok, fs_clk_ok, domain_off_r,
						error_r, done_r, busy};
					`UCC_OFS_STAB: HRDATA <= stab_r;
					default: HRDATA <= 32'h00000000;
				endcase
				if (HADDR[31:4] != 28'h0000000)
					HRDATA <= 32'h00000000;
			end
			if (wr_pend_r) begin
				case (wr_ofs_r)
					`UCC_OFS_CTRL: protocol_r <= HWDATA[`UCC_CTRL_PROTOCOL];
					// Polarity 1 is normal, 0 reverses both lines; reserved bits are kept at 0.
					`UCC_OFS_CFG: cfg_r <= HWDATA[15:0] & `UCC_SCR_WR_MASK;
					`UCC_OFS_STAB: stab_r <= HWDATA;
					default: ;
				endcase
			end
			// Write-one-to-clear; a new event in the same cycle wins.
			if (wr_pend_r && wr_ofs_r == `UCC_OFS_STATUS) begin
				if (HWDATA[`UCC_ST_DONE])
					done_r <= 1'b0;
				if (HWDATA[`UCC_ST_ERROR])
					error_r <= 1'b0;
			end
			if (seq_end)
				done_r <= 1'b1;
			if (poll_fail || cmd_refused)
				error_r <= 1'b1;
			if (seq_end && mode_r == M_SHUT)
				domain_off_r <= 1'b1;
			else if (seq_end && mode_r == M_WAKE)
				domain_off_r <= 1'b0;
		end
	end

	dev_access #(
		.AW(16),
		.DW(16)
	) u_access (
		.clk(CLK_SYS),
		.rst(RST),
		.start(acc_start),
		.wr(acc_wr),
		.addr(st_addr),
		.wdata(acc_wdata),
		.done_r(acc_done),
		.rdata_r(acc_rdata),
		.req_r(DEV_REQ),
		.we_r(DEV_WE),
		.addr_r(DEV_ADDR),
		.wdata_r(DEV_WDATA),
		.dev_rdata(DEV_RDATA),
		.dev_ack(DEV_ACK)
	);
endmodule

// [tb/seq_checker.sv]
// Port assertions for the USB clock sequencer.
// Assumes one device access per request and the device addresses of the shared defines.
`timescale 1ns/1ns
`include "usb_clkctl_defines.vh"
module seq_checker #(
	parameter [31:0] STAB_CYCLES = 8
) (
	input wire CLK_SYS,
	input wire RST,
	input wire DEV_REQ,
	input wire DEV_WE,
	input wire [15:0] DEV_ADDR,
	input wire [15:0] DEV_WDATA,
	input wire [15:0] DEV_RDATA,
	input wire DEV_ACK
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	wire fin = DEV_REQ && DEV_ACK;
	wire wr = fin && DEV_WE;
	wire [15:0] d = DEV_WDATA;
	wire at_cs = DEV_ADDR == `UCC_CLOCK_STOP_HANDSHAKE_REG_ADDR;
	wire at_pg = DEV_ADDR == `UCC_CLOCK_GATING_CTRL_2_ADDR;
	wire at_pm = DEV_ADDR == `UCC_PMR_ADDR;
	wire at_sc = DEV_ADDR == `UCC_SCR_ADDR;
	// Flags only remember accesses seen since reset, so nothing is assumed of the device's start state.
	reg susp_r, seen_r, ungated_r, reqclr_r, oscon_r;
	reg [31:0] osc_r;
	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			susp_r <= 1'b0;
			seen_r <= 1'b0;
			ungated_r <= 1'b0;
			reqclr_r <= 1'b0;
			oscon_r <= 1'b0;
			osc_r <= 32'h0;
		end else begin
			if (wr && at_pm) susp_r <= d[0];
			if (fin && !DEV_WE && at_cs && DEV_RDATA[3]) seen_r <= 1'b1;
			if (wr && at_cs) seen_r <= 1'b0;
			if (wr && at_pg) ungated_r <= !d[0];
			if (wr && at_cs) reqclr_r <= !d[2];
			if (wr && at_sc) oscon_r <= !d[2];
			if (wr && at_sc && !d[2] && !oscon_r) osc_r <= 32'h0;
			else if (!osc_r[31]) osc_r <= osc_r + 32'h1;
		end
	end
	property p_hold;
		DEV_REQ && !DEV_ACK |=> DEV_REQ && $stable(DEV_ADDR) && $stable(DEV_WE) && $stable(DEV_WDATA);
	endproperty
	a_hold: assert property (p_hold) else $error("device request changed before its answer");
	property p_drop;
		fin |=> !DEV_REQ;
	endproperty
	a_drop: assert property (p_drop) else $error("device request stayed after answer");
	property p_susp_first;
		wr && at_cs && d[2] |-> susp_r;
	endproperty
	a_susp_first: assert property (p_susp_first) else $error("stop request before suspend");
	property p_ack_first;
		wr && at_pg && d[0] |-> seen_r;
	endproperty
	a_ack_first: assert property (p_ack_first) else $error("clock gated before acknowledge");
	property p_stab;
		wr && at_pg && !d[0] |-> oscon_r && osc_r >= STAB_CYCLES;
	endproperty
	a_stab: assert property (p_stab) else $error("clock ungated before oscillator settled");
	property p_ungate_first;
		wr && at_cs && !d[2] |-> ungated_r;
	endproperty
	a_ungate_first: assert property (p_ungate_first) else $error("stop request cleared while gated");
	property p_req_clr_first;
		wr && at_pm && !d[0] |-> reqclr_r;
	endproperty
	a_req_clr_first: assert property (p_req_clr_first) else $error("suspend cleared before request");
	property p_rsvd;
		wr && at_sc |-> (d & ~`UCC_SCR_WR_MASK) == 16'h0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved control bits written as one");
endmodule
bind usb_clk_sequencer seq_checker #(.STAB_CYCLES(STAB_CYCLES)) chk (.CLK_SYS(CLK_SYS), .RST(RST),
	.DEV_REQ(DEV_REQ), .DEV_WE(DEV_WE), .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA),
	.DEV_RDATA(DEV_RDATA), .DEV_ACK(DEV_ACK));

// [tb/usb_dev_model.sv]
// Behavioural model of the USB device registers behind the device port.
// Assumes one request at a time, held until the one-cycle acknowledge.
`timescale 1ns/1ns
`include "usb_clkctl_defines.vh"
module usb_dev_model (
	input wire clk,
	input wire rst,
	input wire req,
	input wire we,
	input wire [15:0] addr,
	input wire [15:0] wdata,
	input wire [1:0] lat,
	input wire block,
	output reg [15:0] rdata,
	output reg ack,
	output reg [15:0] scr,
	output reg [15:0] pmr,
	output reg [15:0] cstop,
	output reg [15:0] pcg
);
	reg [1:0] wait_r;
	reg [1:0] quiet_r;
	// The serial side runs from the oscillator PLL, the register side from the system clock.
	wire osc_run = !scr[`UCC_SCR_OSCDIS];
	wire pll_run = !scr[`UCC_SCR_PWDN] || scr[`UCC_SCR_PLLOVR];
	wire pol_normal = scr[`UCC_SCR_POL];
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			scr <= `UCC_SCR_RESET;
			pmr <= 16'h0001;
			cstop <= 16'h000C;
			pcg <= 16'h0001;
			rdata <= 16'h0000;
			ack <= 1'b0;
			wait_r <= 2'h0;
			quiet_r <= 2'h0;
		end else begin
			ack <= 1'b0;
			// A released data bus must not keep showing the last answer.
			rdata <= ~rdata;
			if (cstop[2] && !block && quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
			if (!cstop[2]) quiet_r <= 2'h0;
			cstop[3] <= cstop[2] && quiet_r == 2'h3;
			if (req && !ack) begin
				if (wait_r != lat) wait_r <= wait_r + 2'h1;
				else begin
					wait_r <= 2'h0;
					ack <= 1'b1;
					if (we && addr == `UCC_SCR_ADDR) scr <= wdata & `UCC_SCR_WR_MASK;
					if (we && addr == `UCC_PMR_ADDR) pmr <= wdata & 16'h0001;
					if (we && addr == `UCC_CLOCK_STOP_HANDSHAKE_REG_ADDR) cstop[2] <= wdata[2];
					if (we && addr == `UCC_CLOCK_GATING_CTRL_2_ADDR) pcg <= wdata & 16'h0001;
					if (!we) rdata <= addr == `UCC_SCR_ADDR ? scr : addr == `UCC_PMR_ADDR ? pmr :
						addr == `UCC_CLOCK_STOP_HANDSHAKE_REG_ADDR ? cstop : addr == `UCC_CLOCK_GATING_CTRL_2_ADDR ? pcg : 16'h0000;
				end
			end
		end
	end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the USB clock sequencer with a device register model.
// Assumes the slave never inserts wait states but waits on HREADYOUT all the same.
`timescale 1ns/1ns
`include "usb_clkctl_defines.vh"
module tb_top;
	reg CLK_SYS = 1'b0;
	reg RST = 1'b1;
	reg HSEL = 1'b0;
	reg [31:0] HADDR = 32'h0;
	reg [1:0] HTRANS = 2'h0;
	reg HWRITE = 1'b0;
	reg [31:0] HWDATA = 32'h0;
	reg [1:0] lat = 2'h0;
	reg block = 1'b0;
	reg chk_r = 1'b0;
	wire HREADYOUT, HRESP, DEV_REQ, DEV_WE, DEV_ACK;
	wire [31:0] HRDATA;
	wire [15:0] DEV_ADDR, DEV_WDATA, DEV_RDATA, scr, pmr, cstop, pcg;
	integer error_cnt = 0;
	integer samples_checked = 0;
	integer seed = 50;
	integer i, k;
	logic [31:0] exp_q[$];
	logic [31:0] rd, cfg, want;
	always #2 CLK_SYS = ~CLK_SYS;
	usb_clk_sequencer #(.STAB_CYCLES(32'd8), .POLL_LIMIT(16'd4)) dut (.CLK_SYS(CLK_SYS), .RST(RST),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .DEV_REQ(DEV_REQ),
		.DEV_WE(DEV_WE), .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA), .DEV_RDATA(DEV_RDATA), .DEV_ACK(DEV_ACK));
	usb_dev_model model (.clk(CLK_SYS), .rst(RST), .req(DEV_REQ), .we(DEV_WE), .addr(DEV_ADDR),
		.wdata(DEV_WDATA), .lat(lat), .block(block), .rdata(DEV_RDATA), .ack(DEV_ACK), .scr(scr),
		.pmr(pmr), .cstop(cstop), .pcg(pcg));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic c);
		@(posedge CLK_SYS);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		@(posedge CLK_SYS);
		while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		chk_r <= c;
		@(posedge CLK_SYS);
		while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
		rd = HRDATA;
		chk_r <= 1'b0;
	endtask
	task rdx(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		ahb(1'b0, a, 32'h0, 1'b1);
	endtask
	// Status is read back and its sticky flags cleared in one go.
	task stat(input logic [31:0] e);
		rdx(`UCC_OFS_STATUS, e);
		ahb(1'b1, `UCC_OFS_STATUS, 32'h6, 1'b0);
	endtask
	task run(input logic [31:0] cmd);
		lat <= $random(seed);
		ahb(1'b1, `UCC_OFS_CTRL, cmd, 1'b0);
		i = 0;
		do begin
			ahb(1'b0, `UCC_OFS_STATUS, 32'h0, 1'b0);
			i = i + 1;
		end while (rd[2:1] == 2'b00 && i < 3000);
		if (i >= 3000) error_cnt = error_cnt + 1;
	endtask
	always @(posedge CLK_SYS) if (chk_r && HREADYOUT === 1'b1) check(HRDATA, exp_q.pop_front());
	initial begin
		#200000;
		error_cnt = error_cnt + 1;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge CLK_SYS);
		RST <= 1'b0;
		rdx(`UCC_OFS_CTRL, 32'h0);
		rdx(`UCC_OFS_CFG, 32'h0000A04C);
		rdx(`UCC_OFS_STATUS, 32'h30);
		ahb(1'b1, 32'h20, 32'hFFFFFFFF, 1'b0);
		rdx(32'h20, 32'h0);
		check({HRESP, HREADYOUT, scr}, {2'b01, `UCC_SCR_RESET});
		ahb(1'b1, `UCC_OFS_STAB, 32'h8, 1'b0);
		rdx(`UCC_OFS_STAB, 32'h8);
		run(32'h2);
		stat(32'h32);
		check({scr[2], pcg[0], cstop[2], pmr[0]}, 32'h0);
		check(model.osc_run, 32'h1);
		want = scr;
		for (k = 0; k < 4; k = k + 1) begin
			cfg = ($random(seed) & 32'hFFFFFFF8) | k;
			ahb(1'b1, `UCC_OFS_CFG, cfg, 1'b0);
			rdx(`UCC_OFS_CFG, cfg & 32'hF04F);
			run(32'h4);
			if (k < 3) want = cfg & 32'hF04F;
			check(scr, want);
			stat(k < 3 ? 32'h32 : 32'h34);
		end
		run(32'h1);
		stat(32'h3A);
		check({scr[2], pcg[0], cstop[2], pmr[0]}, 32'hF);
		check(model.osc_run, 32'h0);
		run(32'h2);
		stat(32'h32);
		block <= 1'b1;
		run(32'h1);
		stat(32'h34);
		check(pcg[0], 32'h0);
		block <= 1'b0;
		run(32'h2);
		stat(32'h32);
		run(32'h9);
		stat(32'h34);
		check(pmr[0], 32'h0);
		rdx(`UCC_OFS_CTRL, 32'h8);
		ahb(1'b1, `UCC_OFS_CTRL, 32'h3, 1'b0);
		rdx(`UCC_OFS_STATUS, 32'h30);
		tally_and_finish;
	end
endmodule
